/* logic/acs_pkg.sv */
package acs_pkg;
	// ==========================================================
	// Register map (APB byte addresses)
	localparam logic [7:0] ACS_OFS_CTRL0  = 8'h00;
	localparam logic [7:0] ACS_OFS_CFG1   = 8'h04;
	localparam logic [7:0] ACS_OFS_CFG2   = 8'h08;
	localparam logic [7:0] ACS_OFS_RES_HI = 8'h0C;
	localparam logic [7:0] ACS_OFS_RES_LO = 8'h10;
	localparam logic [7:0] ACS_OFS_STAT   = 8'h14;
	// ==========================================================
	// Field positions
	localparam int ACS_B_ON      = 0;
	localparam int ACS_B_GO      = 1;
	localparam int ACS_B_CHS_LO  = 2;
	localparam int ACS_B_PCF_LO  = 0;
	localparam int ACS_B_POSREF  = 4;
	localparam int ACS_B_NEGREF  = 5;
	localparam int ACS_B_CKS_LO  = 0;
	localparam int ACS_B_ACQ_LO  = 3;
	localparam int ACS_B_FMT     = 7;
	localparam int ACS_B_DONE    = 0;
	// ==========================================================
	// Reset values
	localparam logic [3:0] ACS_PCF_RST_ANA = 4'h0;
	localparam logic [3:0] ACS_PCF_RST_DIG = 4'h7;
	localparam logic [7:0] ACS_CFG2_RST    = 8'h00;
	// ==========================================================
	// Geometry and timing
	localparam int ACS_NCH       = 13;
	localparam int ACS_NBITS     = 12;
	localparam int ACS_TCY_CLKS  = 4;
	localparam int ACS_POST_TCY  = 2;
	localparam int ACS_POST_CLKS = ACS_POST_TCY * ACS_TCY_CLKS;
	localparam int ACS_DISCH_TAD = 1;
	localparam int ACS_RC_DIV    = 8;
	localparam logic [3:0] ACS_PCF_ALLD = 4'hF;
	typedef enum logic [2:0] {
		ACS_IDLE, ACS_START, ACS_ACQ, ACS_DISCH, ACS_CONV, ACS_POST
	} acs_state_t;
endpackage

/* logic/acs_adc_control_sequencer.sv */
// Implementation choices: the register addresses and the APB register port.
module acs_adc_control_sequencer
	import acs_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 portb_analog_default,
	input  wire logic                 sleep_mode,
	input  wire logic                 cmp_bit,
	output logic      [ACS_NCH-1:0]   pin_analog,
	output logic      [3:0]           channel_sel,
	output logic                      neg_ref_ext,
	output logic                      pos_ref_ext,
	output logic                      sample_en,
	output logic                      discharge_en,
	output logic      [ACS_NBITS-1:0] dac_code,
	output logic                      conv_done_flag
);
	// ==========================================================
	// Register bus
	logic              wr_en;
	logic              rd_en;
	logic              converter_on_q;
	logic              go_q;
	logic [3:0]        chs_q;
	logic              negref_q;
	logic              posref_q;
	logic [3:0]        pcf_q;
	logic              result_format_q;
	logic [2:0]        acq_time_sel_q;
	logic [2:0]        conv_clock_sel_q;
	logic [7:0]        result_high_q;
	logic [7:0]        result_low_q;
	logic              done_q;
	logic [1:0]        strap_cnt_q;
	logic              strap_s1_q;
	logic              strap_s2_q;
	logic              complete;
	logic              abort;
	logic [15:0]       result_word;
	acs_state_t        state_q;

	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pslverr = psel && penable && !(paddr == ACS_OFS_CTRL0
		|| paddr == ACS_OFS_CFG1 || paddr == ACS_OFS_CFG2
		|| paddr == ACS_OFS_RES_HI || paddr == ACS_OFS_RES_LO
		|| paddr == ACS_OFS_STAT);

	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			ACS_OFS_CTRL0:  prdata[5:0] = {chs_q, go_q, converter_on_q};
			ACS_OFS_CFG1:   prdata[5:0] = {negref_q, posref_q, pcf_q};
			ACS_OFS_CFG2:   prdata[7:0] = {result_format_q, 1'b0,
				acq_time_sel_q, conv_clock_sel_q};
			ACS_OFS_RES_HI: prdata[7:0] = result_high_q;
			ACS_OFS_RES_LO: prdata[7:0] = result_low_q;
			ACS_OFS_STAT:   prdata[ACS_B_DONE] = done_q;
			default:        prdata = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// Strap synchroniser and load timer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_s1_q  <= 1'b0;
			strap_s2_q  <= 1'b0;
			strap_cnt_q <= 2'd0;
		end else begin
			strap_s1_q <= portb_analog_default;
			strap_s2_q <= strap_s1_q;
			if (strap_cnt_q != 2'd3)
				strap_cnt_q <= strap_cnt_q + 2'd1;
		end
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_on_q   <= 1'b0;
			chs_q            <= 4'h0;
			negref_q         <= 1'b0;
			posref_q         <= 1'b0;
			pcf_q            <= ACS_PCF_RST_ANA;
			result_format_q  <= ACS_CFG2_RST[ACS_B_FMT];
			acq_time_sel_q   <= ACS_CFG2_RST[ACS_B_ACQ_LO +: 3];
			conv_clock_sel_q <= ACS_CFG2_RST[ACS_B_CKS_LO +: 3];
		end else begin
			if (strap_cnt_q == 2'd2)
				pcf_q <= strap_s2_q ? ACS_PCF_RST_ANA
					: ACS_PCF_RST_DIG;
			if (wr_en && paddr == ACS_OFS_CTRL0) begin
				converter_on_q <= pwdata[ACS_B_ON];
				chs_q <= pwdata[ACS_B_CHS_LO +: 4];
			end
			if (wr_en && paddr == ACS_OFS_CFG1) begin
				negref_q <= pwdata[ACS_B_NEGREF];
				posref_q <= pwdata[ACS_B_POSREF];
				pcf_q    <= pwdata[ACS_B_PCF_LO +: 4];
			end
			if (wr_en && paddr == ACS_OFS_CFG2) begin
				result_format_q  <= pwdata[ACS_B_FMT];
				acq_time_sel_q   <= pwdata[ACS_B_ACQ_LO +: 3];
				conv_clock_sel_q <= pwdata[ACS_B_CKS_LO +: 3];
			end
		end
	end

	// ==========================================================
	// Pin and reference outputs
	assign neg_ref_ext = negref_q;
	assign pos_ref_ext = posref_q;
	// Codes 13..15 pass through; converter reads a floating node
	assign channel_sel = chs_q;

	always_comb begin
		logic [3:0] n_ana;
		n_ana = 4'd0;
		unique case (pcf_q)
			4'h0, 4'h1, 4'h2: n_ana = 4'd13;
			4'h3:             n_ana = 4'd12;
			4'h4:             n_ana = 4'd11;
			4'h5:             n_ana = 4'd10;
			4'h6:             n_ana = 4'd9;
			4'h7:             n_ana = 4'd8;
			4'h8, 4'h9:       n_ana = 4'd7;
			4'hA:             n_ana = 4'd6;
			4'hB:             n_ana = 4'd5;
			4'hC:             n_ana = 4'd3;
			4'hD:             n_ana = 4'd2;
			4'hE:             n_ana = 4'd1;
			ACS_PCF_ALLD:     n_ana = 4'd0;
		endcase
		for (int i = 0; i < ACS_NCH; i++)
			pin_analog[i] = (i < int'(n_ana));
	end

	// ==========================================================
	// Bit-period clock enable
	logic       is_rc;
	logic [6:0] div_max;
	logic [6:0] div_q;
	logic       tad_tick;
	logic [2:0] rc_q;
	assign is_rc = (conv_clock_sel_q[1:0] == 2'b11);
	always_comb begin
		unique case (conv_clock_sel_q)
			3'b000:  div_max = 7'd1;
			3'b001:  div_max = 7'd7;
			3'b010:  div_max = 7'd31;
			3'b100:  div_max = 7'd3;
			3'b101:  div_max = 7'd15;
			3'b110:  div_max = 7'd63;
			default: div_max = 7'(ACS_RC_DIV - 1);
		endcase
	end
	// Oscillator-derived periods stop in sleep; RC keeps running
	assign tad_tick = (div_q == div_max) && (is_rc || !sleep_mode);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			div_q <= 7'd0;
		else if (state_q == ACS_IDLE || state_q == ACS_START
			|| div_q >= div_max)
			div_q <= 7'd0;
		else if (is_rc || !sleep_mode)
			div_q <= div_q + 7'd1;
	end

	// ==========================================================
	// Sequencer
	logic [4:0] acq_tad;
	logic [4:0] cnt_q;
	logic [3:0] bit_q;
	logic [3:0] start_q;
	logic [3:0] start_len;
	logic [ACS_NBITS-1:0] sar_q;
	always_comb begin
		unique case (acq_time_sel_q)
			3'b000: acq_tad = 5'd0;
			3'b001: acq_tad = 5'd2;
			3'b010: acq_tad = 5'd4;
			3'b011: acq_tad = 5'd6;
			3'b100: acq_tad = 5'd8;
			3'b101: acq_tad = 5'd12;
			3'b110: acq_tad = 5'd16;
			3'b111: acq_tad = 5'd20;
		endcase
	end
	// One instruction for a sleep to land, plus one more on RC clock with zero acquisition time
	assign start_len = (is_rc && acq_tad == 5'd0) ? 4'(2 * ACS_TCY_CLKS)
		: 4'(ACS_TCY_CLKS);

	logic go_wr1;
	logic go_wr0;
	assign go_wr1 = wr_en && paddr == ACS_OFS_CTRL0 && pwdata[ACS_B_GO]
		&& pwdata[ACS_B_ON] && converter_on_q;
	assign go_wr0 = wr_en && paddr == ACS_OFS_CTRL0
		&& !(pwdata[ACS_B_GO] && pwdata[ACS_B_ON]);
	assign abort    = go_q && go_wr0;
	assign complete = state_q == ACS_CONV && tad_tick
		&& bit_q == 4'd0 && !go_wr0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ACS_IDLE;
			cnt_q   <= 5'd0;
			bit_q   <= 4'd0;
			start_q <= 4'd0;
			sar_q   <= '0;
			go_q    <= 1'b0;
		end else if (abort || (go_q && !converter_on_q)) begin
			go_q    <= 1'b0;
			state_q <= ACS_POST;
			cnt_q   <= 5'd0;
		end else begin
			unique case (state_q)
				ACS_IDLE: if (go_wr1) begin
					go_q    <= 1'b1;
					start_q <= 4'd0;
					state_q <= (acq_tad == 5'd0 || is_rc) ? ACS_START
						: ACS_ACQ;
					cnt_q   <= 5'd0;
				end
				ACS_START: begin
					start_q <= start_q + 4'd1;
					if (start_q + 4'd1 >= start_len) begin
						state_q <= (acq_tad == 5'd0) ? ACS_DISCH
							: ACS_ACQ;
						cnt_q   <= 5'd0;
					end
				end
				ACS_ACQ: if (tad_tick) begin
					cnt_q <= cnt_q + 5'd1;
					if (cnt_q + 5'd1 >= acq_tad) begin
						state_q <= ACS_DISCH;
						cnt_q   <= 5'd0;
					end
				end
				ACS_DISCH: if (tad_tick) begin
					state_q <= ACS_CONV;
					bit_q   <= 4'(ACS_NBITS - 1);
					sar_q   <= {1'b1, {(ACS_NBITS-1){1'b0}}};
				end
				ACS_CONV: if (tad_tick) begin
					sar_q[bit_q] <= cmp_bit;
					if (bit_q != 4'd0)
						sar_q[bit_q - 4'd1] <= 1'b1;
					if (bit_q == 4'd0) begin
						go_q    <= 1'b0;
						state_q <= ACS_POST;
						cnt_q   <= 5'd0;
					end else
						bit_q <= bit_q - 4'd1;
				end
				ACS_POST: begin
					cnt_q <= cnt_q + 5'd1;
					if (cnt_q + 5'd1 >= 5'(ACS_POST_CLKS))
						state_q <= ACS_IDLE;
				end
			endcase
		end
	end

	// Auto acquisition tracks selected channel while idle
	assign sample_en    = converter_on_q && (state_q == ACS_IDLE
		|| state_q == ACS_ACQ || state_q == ACS_START);
	assign discharge_en = state_q == ACS_DISCH;
	assign dac_code     = sar_q;

	// ==========================================================
	// Result pair and done flag
	logic [ACS_NBITS-1:0] final_res;
	always_comb begin
		final_res    = sar_q;
		final_res[0] = cmp_bit;
	end
	assign result_word = result_format_q
		? {4'h0, final_res} : {final_res, 4'h0};

	// No reset: contents survive warm resets
	always_ff @(posedge clk) begin
		if (complete) begin
			result_high_q <= result_word[15:8];
			result_low_q  <= result_word[7:0];
		end else begin
			if (wr_en && paddr == ACS_OFS_RES_HI)
				result_high_q <= pwdata[7:0];
			if (wr_en && paddr == ACS_OFS_RES_LO)
				result_low_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			done_q <= 1'b0;
		else if (complete)
			done_q <= 1'b1;
		else if (wr_en && paddr == ACS_OFS_STAT && pwdata[ACS_B_DONE])
			done_q <= 1'b0;
	end
	assign conv_done_flag = done_q;

	// ==========================================================
	// Checks
	property p_done_set;
		@(posedge clk) disable iff (!rst_n) complete |=> done_q;
	endproperty
	a_done_set: assert property (p_done_set)
		else $error("done flag not set");

	property p_go_clear;
		@(posedge clk) disable iff (!rst_n) complete |=> !go_q;
	endproperty
	a_go_clear: assert property (p_go_clear)
		else $error("go not cleared");

	property p_abort;
		@(posedge clk) disable iff (!rst_n)
			abort |=> !go_q && state_q == ACS_POST;
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort missed");

	property p_post_len;
		@(posedge clk) disable iff (!rst_n)
			$rose(state_q == ACS_POST) |-> (state_q == ACS_POST)[*8];
	endproperty
	a_post_len: assert property (p_post_len)
		else $error("post wait short");

	property p_disch;
		@(posedge clk) disable iff (!rst_n)
			$rose(state_q == ACS_CONV) |-> $past(state_q) == ACS_DISCH;
	endproperty
	a_disch: assert property (p_disch)
		else $error("no discharge");

	property p_all_dig;
		@(posedge clk) disable iff (!rst_n)
			pcf_q == ACS_PCF_ALLD |-> pin_analog == '0;
	endproperty
	a_all_dig: assert property (p_all_dig)
		else $error("pins not digital");

	property p_fmt;
		@(posedge clk) disable iff (!rst_n)
			complete && result_format_q |=> result_high_q[7:4] == 4'h0;
	endproperty
	a_fmt: assert property (p_fmt)
		else $error("right format high nibble");

	property p_start;
		@(posedge clk) disable iff (!rst_n)
			go_wr1 && state_q == ACS_IDLE && acq_tad == 5'd0 && !is_rc
			|=> (state_q == ACS_START)[*4] ##1 state_q == ACS_DISCH;
	endproperty
	a_start: assert property (p_start)
		else $error("start delay wrong");

	c_complete: cover property (@(posedge clk) complete);
	c_abort:    cover property (@(posedge clk) abort);
	c_acq:      cover property (@(posedge clk) state_q == ACS_ACQ);
endmodule

/* bench/acs_analog_model.sv */
module acs_analog_model
	import acs_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic [3:0]           channel_sel,
	input  wire logic [ACS_NCH-1:0]   pin_analog,
	input  wire logic [ACS_NBITS-1:0] dac_code,
	output logic                      cmp_bit
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Comparator behind the sample and hold
	logic [ACS_NBITS-1:0] level;
	logic                 flip_q = 1'b0;
	assign level = 12'h135 * {8'h00, channel_sel} + 12'h0A5;
	always @(posedge clk) begin
		flip_q <= ~flip_q;
		if (channel_sel > 4'hC || !pin_analog[channel_sel]) begin
			cmp_bit <= flip_q;
		end else begin
			cmp_bit <= (level >= dac_code);
		end
	end
endmodule

/* bench/tb.sv */
module tb
	import acs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals
	logic                 clk, rst_n, psel, penable, pwrite;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, rd;
	logic                 pready, pslverr, err, strap, sleep_mode;
	logic                 cmp_bit, neg_ref_ext, pos_ref_ext;
	logic                 sample_en, discharge_en, conv_done_flag;
	logic [ACS_NCH-1:0]   pin_analog;
	logic [3:0]           channel_sel;
	logic [ACS_NBITS-1:0] dac_code, v;
	logic [15:0]          r16;
	logic [3:0]           chs [8] = '{4'h0, 4'h3, 4'h5, 4'h8,
	                                  4'hC, 4'h1, 4'hB, 4'h7};
	int                   dv [8] = '{2, 8, 32, 8, 4, 16, 64, 8};
	int                   conv_bit_period [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	int                   nd [16] = '{0, 0, 0, 1, 2, 3, 4, 5,
	                                  6, 6, 7, 8, 10, 11, 12, 13};
	int                   failures, comparisons, n;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	acs_adc_control_sequencer i_acs_adc_control_sequencer (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portb_analog_default(strap), .sleep_mode(sleep_mode),
		.cmp_bit(cmp_bit), .pin_analog(pin_analog),
		.channel_sel(channel_sel), .neg_ref_ext(neg_ref_ext),
		.pos_ref_ext(pos_ref_ext), .sample_en(sample_en),
		.discharge_en(discharge_en), .dac_code(dac_code),
		.conv_done_flag(conv_done_flag)
	);
	acs_analog_model i_acs_analog_model (
		.clk(clk), .channel_sel(channel_sel), .pin_analog(pin_analog),
		.dac_code(dac_code), .cmp_bit(cmp_bit)
	);
	// ==========================================================
	// Tasks
	task automatic summarize;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
	                   input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
	                   input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			chk("pready_wait", 1, 0);
			summarize;
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
	                      input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask
	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			apb(1'b0, ACS_OFS_CTRL0, 32'h0000_0000);
			k++;
		end while (rd[ACS_B_GO] !== 1'b0 && k < 2000);
		if (k >= 2000) begin
			chk("go_wait", 1, 0);
			summarize;
		end
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	function automatic logic [31:0] ctl(input logic [3:0] c,
	                                    input logic g, input logic o);
		return 32'({c, g, o});
	endfunction
	// ==========================================================
	// Main sequence
	initial begin
		failures = 0;
		comparisons = 0;
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		strap = 1'b1;
		sleep_mode = 1'b0;
		do_reset;
		rd_chk(ACS_OFS_CTRL0, 0, "ctrl0_rst");
		rd_chk(ACS_OFS_CFG1, 0, "cfg1_rst");
		rd_chk(ACS_OFS_CFG2, 32'(ACS_CFG2_RST), "cfg2_rst");
		apb(1'b1, ACS_OFS_CTRL0, ctl(4'h0, 1'b1, 1'b1));
		rd_chk(ACS_OFS_CTRL0, ctl(4'h0, 1'b0, 1'b1), "go_on");
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, ACS_OFS_CFG1, 32'(c + 16 * (c % 4)));
			@(negedge clk);
			chk("pins", 32'(13'h1FFF >> nd[c]), 32'(pin_analog));
			chk("neg_ref", c / 2 % 2, 32'(neg_ref_ext));
			chk("pos_ref", c % 2, 32'(pos_ref_ext));
		end
		apb(1'b1, ACS_OFS_CFG1, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, ACS_OFS_CFG2, 32'({i % 2, 1'b0, i[2:0], i[2:0]}));
			sleep_mode <= (i % 4 == 3);
			apb(1'b1, ACS_OFS_CTRL0, ctl(chs[i], 1'b0, 1'b1));
			repeat (20) @(posedge clk);
			apb(1'b1, ACS_OFS_CTRL0, ctl(chs[i], 1'b1, 1'b1));
			n = 0;
			while (discharge_en !== 1'b1 && n < 3000) begin
				@(posedge clk);
				n++;
			end
			chk("acq", 1, n >= conv_bit_period[i] * dv[i] && n < 3000);
			wait_idle;
			v = 12'h135 * {8'h00, chs[i]} + 12'h0A5;
			r16 = (i % 2) ? {4'h0, v} : {v, 4'h0};
			rd_chk(ACS_OFS_RES_HI, r16[15:8], "res_hi");
			rd_chk(ACS_OFS_RES_LO, r16[7:0], "res_lo");
			rd_chk(ACS_OFS_STAT, 1, "done");
			chk("done_pin", 1, 32'(conv_done_flag));
			apb(1'b1, ACS_OFS_STAT, 32'h0000_0001);
			rd_chk(ACS_OFS_STAT, 0, "done_clr");
			chk("sample", 1, 32'(sample_en));
			sleep_mode <= 1'b0;
		end
		apb(1'b1, ACS_OFS_CFG2, 32'h0000_0006);
		apb(1'b1, ACS_OFS_CTRL0, ctl(4'h4, 1'b1, 1'b1));
		repeat (100) @(posedge clk);
		apb(1'b1, ACS_OFS_CTRL0, ctl(4'h4, 1'b0, 1'b1));
		rd_chk(ACS_OFS_CTRL0, ctl(4'h4, 1'b0, 1'b1), "abort");
		repeat (2400) @(posedge clk);
		rd_chk(ACS_OFS_RES_LO, r16[7:0], "abort_res");
		rd_chk(ACS_OFS_STAT, 0, "abort_done");
		// ==========================================================
		// Oscillator-derived bit periods freeze in sleep
		apb(1'b1, ACS_OFS_CFG2, 32'h0000_0005);
		sleep_mode <= 1'b1;
		apb(1'b1, ACS_OFS_CTRL0, ctl(4'h4, 1'b1, 1'b1));
		repeat (200) @(posedge clk);
		rd_chk(ACS_OFS_CTRL0, ctl(4'h4, 1'b1, 1'b1), "sleep_hold");
		sleep_mode <= 1'b0;
		wait_idle;
		rd_chk(ACS_OFS_STAT, 1, "sleep_done");
		v = 12'h135 * 12'h004 + 12'h0A5;
		r16 = {v, 4'h0};
		rd_chk(ACS_OFS_RES_HI, r16[15:8], "sleep_res");
		repeat (10) @(posedge clk);
		strap <= 1'b0;
		apb(1'b1, ACS_OFS_CTRL0, ctl(4'h2, 1'b1, 1'b1));
		repeat (50) @(posedge clk);
		do_reset;
		rd_chk(ACS_OFS_CTRL0, 0, "ctrl0_rst2");
		rd_chk(ACS_OFS_CFG1, 32'(ACS_PCF_RST_DIG), "cfg1_rst2");
		rd_chk(ACS_OFS_RES_HI, r16[15:8], "res_keep");
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk("unmapped", 1, 32'(err));
		apb(1'b1, ACS_OFS_CFG1, 32'h0000_0000);
		apb(1'b1, ACS_OFS_CTRL0, ctl(4'hD, 1'b0, 1'b1));
		repeat (20) @(posedge clk);
		apb(1'b1, ACS_OFS_CTRL0, ctl(4'hD, 1'b1, 1'b1));
		wait_idle;
		rd_chk(ACS_OFS_STAT, 1, "float_done");
		chk("float_err", 0, 32'(err));
		summarize;
	end
endmodule
